/* core/dcs_defines.svh */
`ifndef DCS_DEFINES_SVH
`define DCS_DEFINES_SVH

// serial word layout
`define DCS_WORD_W 11
`define DCS_CODE_W 9
`define DCS_CHSEL_BIT 0
`define DCS_MODE_BIT 1
`define DCS_CODE_LSB 2
`define DCS_CODE_MSB 10

// field values
`define DCS_CH_A 1'b0
`define DCS_CH_B 1'b1
`define DCS_MODE_DUAL 1'b0
`define DCS_MODE_EXT 1'b1

// reset values
`define DCS_CODE_RST 9'h000
`define DCS_WORD_RST 11'h000

// shift clock timing
`define DCS_SYS_MHZ 100
`define DCS_SCLK_MAX_MHZ 20
`define DCS_SCLK_HALF_CYC \
  ((`DCS_SYS_MHZ + 2 * `DCS_SCLK_MAX_MHZ - 1) / (2 * `DCS_SCLK_MAX_MHZ))

`endif

/* core/dcs_pkg.sv */
package dcs_pkg;

  typedef enum logic {
    DCS_PATH_DUAL,
    DCS_PATH_EXT
  } dcs_path_t;

  typedef enum logic [1:0] {
    DCS_H_IDLE,
    DCS_H_SHIFT,
    DCS_H_STROBE,
    DCS_H_TAIL
  } dcs_hstate_t;

endpackage

/* core/dcs_link_if.sv */
`timescale 1ns/100ps
interface dcs_link_if;
  logic shiftClk;
  logic serialDataIn;
  logic latchStrobe;

  modport host (
    output shiftClk,
    output serialDataIn,
    output latchStrobe
  );

  modport device (
    input shiftClk,
    input serialDataIn,
    input latchStrobe
  );
endinterface

/* core/dcs_delay_chan.sv */
`timescale 1ns/100ps
`include "dcs_defines.svh"
module dcs_delay_chan #(
  parameter int CODE_W = `DCS_CODE_W
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // signal path
  input wire logic din,
  input wire logic [CODE_W-1:0] code,
  output logic dout
);
  localparam int DEPTH = 2 ** CODE_W;

  logic [DEPTH-1:0] hist;
  logic [DEPTH-1:0] next_hist;
  logic next_dout;

  // each code bit adds a binary-weighted number of cycles
  always_comb
  begin
    next_hist = {hist[DEPTH-2:0], din};
    if (code == '0)
      next_dout = din;
    else
      next_dout = hist[code - CODE_W'(1)];
    if (srst)
    begin
      next_hist = '0;
      next_dout = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    hist <= next_hist;
    dout <= next_dout;
  end
endmodule

/* core/dcs_host.sv */
`timescale 1ns/100ps
`include "dcs_defines.svh"
module dcs_host #(
  parameter int HALF_CYC = `DCS_SCLK_HALF_CYC
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // serial link
  dcs_link_if.host link,
  // user command
  input wire logic cfgReq,
  input wire logic cfgChannel,
  input wire logic cfgMode,
  input wire logic [`DCS_CODE_W-1:0] cfgCode,
  output logic cfgBusy,
  output logic cfgDone,
  output logic bothLoaded
);
  dcs_pkg::dcs_hstate_t state, next_state;
  logic [`DCS_WORD_W-1:0] txWord, next_txWord;
  logic [3:0] bitCnt, next_bitCnt;
  logic [7:0] halfCnt, next_halfCnt;
  logic sclk, next_sclk;
  logic sdo, next_sdo;
  logic stb, next_stb;
  logic txChan, next_txChan;
  logic [1:0] loaded, next_loaded;
  logic next_busy, next_done, next_both;
  logic tick;

  assign link.shiftClk = sclk;
  assign link.serialDataIn = sdo;
  assign link.latchStrobe = stb;

  always_comb
  begin
    next_state = state;
    next_txWord = txWord;
    next_bitCnt = bitCnt;
    next_halfCnt = halfCnt;
    next_sclk = sclk;
    next_sdo = sdo;
    next_stb = stb;
    next_txChan = txChan;
    next_loaded = loaded;
    next_done = 1'b0;
    tick = 1'b0;
    // shift clock divided from the system clock, kept under its ceiling
    if (state != dcs_pkg::DCS_H_IDLE)
    begin
      if (halfCnt == 8'(HALF_CYC - 1))
      begin
        next_halfCnt = 8'h00;
        tick = 1'b1;
        next_sclk = ~sclk;
      end
      else
        next_halfCnt = halfCnt + 8'h01;
    end
    case (state)
      dcs_pkg::DCS_H_IDLE:
      begin
        if (cfgReq)
        begin
          // one word per channel, channel bit first on the wire
          next_txWord = {cfgCode, cfgMode, cfgChannel};
          next_sdo = cfgChannel;
          next_txChan = cfgChannel;
          next_bitCnt = 4'h0;
          next_halfCnt = 8'h00;
          next_state = dcs_pkg::DCS_H_SHIFT;
        end
      end
      dcs_pkg::DCS_H_SHIFT:
      begin
        if (tick && sclk)
        begin
          if (bitCnt == 4'(`DCS_WORD_W - 1))
          begin
            next_stb = 1'b1;
            next_state = dcs_pkg::DCS_H_STROBE;
          end
          else
          begin
            next_bitCnt = bitCnt + 4'h1;
            next_txWord = {1'b0, txWord[`DCS_WORD_W-1:1]};
            next_sdo = txWord[1];
          end
        end
      end
      dcs_pkg::DCS_H_STROBE:
      begin
        if (tick && sclk)
        begin
          next_stb = 1'b0;
          next_state = dcs_pkg::DCS_H_TAIL;
        end
      end
      dcs_pkg::DCS_H_TAIL:
      begin
        if (tick && sclk)
        begin
          next_done = 1'b1;
          next_loaded[txChan] = 1'b1;
          next_state = dcs_pkg::DCS_H_IDLE;
        end
      end
      default:
        next_state = dcs_pkg::DCS_H_IDLE;
    endcase
    next_busy = (next_state != dcs_pkg::DCS_H_IDLE);
    next_both = &next_loaded;
    if (srst)
    begin
      next_state = dcs_pkg::DCS_H_IDLE;
      next_txWord = `DCS_WORD_RST;
      next_bitCnt = 4'h0;
      next_halfCnt = 8'h00;
      next_sclk = 1'b0;
      next_sdo = 1'b0;
      next_stb = 1'b0;
      next_txChan = 1'b0;
      next_loaded = 2'b00;
      next_busy = 1'b0;
      next_done = 1'b0;
      next_both = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    state <= next_state;
    txWord <= next_txWord;
    bitCnt <= next_bitCnt;
    halfCnt <= next_halfCnt;
    sclk <= next_sclk;
    sdo <= next_sdo;
    stb <= next_stb;
    txChan <= next_txChan;
    loaded <= next_loaded;
    cfgBusy <= next_busy;
    cfgDone <= next_done;
    bothLoaded <= next_both;
  end
endmodule

/* core/dcs_device.sv */
`timescale 1ns/100ps
`include "dcs_defines.svh"
// Contract
// - words enter through an eleven-bit shift register
// - word holds channel bit, mode bit, nine-bit code
// - controller loads each channel with its own word
// - controller loads both channels after power-up; dcs_host loads only on cfgReq and just reports it on bothLoaded
// - dual mode uses mode bit zero
// - each code bit adds binary-weighted delay
// - shift clock stays under its maximum rate
// - dual mode routes each pair independently
// - extended mode cascades pair a into pair b
// - register shifts each rising edge, channel bit first
// - strobe rise loads latch, fall holds it
// - channel bit selects which latch loads
// - extended mode forces output pair a static
module dcs_device #(
  parameter int CODE_W = `DCS_CODE_W
)(
  // system clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // serial link
  dcs_link_if.device link,
  // input pairs
  input wire logic inputPairA_p,
  input wire logic inputPairA_n,
  input wire logic inputPairB_p,
  input wire logic inputPairB_n,
  // output pairs
  output logic outputPairA_p,
  output logic outputPairA_n,
  output logic outputPairB_p,
  output logic outputPairB_n,
  // configuration status
  output logic [CODE_W-1:0] delayChannelA,
  output logic [CODE_W-1:0] delayChannelB,
  output logic pathModeBit
);
  // link clock domain
  logic linkRstMeta, linkRst;
  logic [`DCS_WORD_W-1:0] shiftWord, next_shiftWord;
  logic strobePrev, next_strobePrev;
  logic [CODE_W-1:0] latchA, next_latchA;
  logic [CODE_W-1:0] latchB, next_latchB;
  logic latchMode, next_latchMode;
  logic latchChan, next_latchChan;
  logic strobeRise;

  // system clock domain
  logic stbMeta, stbSync;
  logic stbSeen, next_stbSeen;
  logic strobeFall;
  logic [3:0] pinMeta, pinSync;
  logic [CODE_W-1:0] next_codeA, next_codeB;
  logic next_mode;
  logic inA, inB, chanBIn, chanAOut, chanBOut;
  logic next_oAp, next_oAn, next_oBp, next_oBn;
  dcs_pkg::dcs_path_t path;

  // reset carried into the link domain
  always_ff @(posedge link.shiftClk)
  begin
    linkRstMeta <= srst;
    linkRst <= linkRstMeta;
  end

  always_comb
  begin
    // shift toward the low end, so the first bit lands in bit zero
    next_shiftWord = {link.serialDataIn, shiftWord[`DCS_WORD_W-1:1]};
    next_strobePrev = link.latchStrobe;
    strobeRise = link.latchStrobe & ~strobePrev;
    next_latchA = latchA;
    next_latchB = latchB;
    next_latchMode = latchMode;
    next_latchChan = latchChan;
    // latch only on the strobe rise; the rest of the cycle it holds
    if (strobeRise)
    begin
      if (shiftWord[`DCS_CHSEL_BIT] == `DCS_CH_A)
        next_latchA = shiftWord[`DCS_CODE_MSB:`DCS_CODE_LSB];
      else
        next_latchB = shiftWord[`DCS_CODE_MSB:`DCS_CODE_LSB];
      next_latchMode = shiftWord[`DCS_MODE_BIT];
      // channel bit kept so the system side copies one latch only
      next_latchChan = shiftWord[`DCS_CHSEL_BIT];
    end
    if (linkRst)
    begin
      next_shiftWord = `DCS_WORD_RST;
      next_strobePrev = 1'b0;
      next_latchA = `DCS_CODE_RST;
      next_latchB = `DCS_CODE_RST;
      next_latchMode = `DCS_MODE_DUAL;
      next_latchChan = `DCS_CH_A;
    end
  end

  always_ff @(posedge link.shiftClk)
  begin
    shiftWord <= next_shiftWord;
    strobePrev <= next_strobePrev;
    latchA <= next_latchA;
    latchB <= next_latchB;
    latchMode <= next_latchMode;
    latchChan <= next_latchChan;
  end

  // strobe and pins brought into the system domain
  always_ff @(posedge clk_sys)
  begin
    stbMeta <= link.latchStrobe;
    stbSync <= stbMeta;
    pinMeta <= {inputPairB_n, inputPairB_p, inputPairA_n, inputPairA_p};
    pinSync <= pinMeta;
  end

  assign inA = pinSync[0] & ~pinSync[1];
  assign inB = pinSync[2] & ~pinSync[3];
  assign path = pathModeBit ? dcs_pkg::DCS_PATH_EXT : dcs_pkg::DCS_PATH_DUAL;

  always_comb
  begin
    next_codeA = delayChannelA;
    next_codeB = delayChannelB;
    next_mode = pathModeBit;
    next_stbSeen = stbSync;
    strobeFall = stbSeen & ~stbSync;
    // latches stood still half a shift period before the strobe fell
    if (strobeFall)
    begin
      if (latchChan == `DCS_CH_A)
        next_codeA = latchA;
      else
        next_codeB = latchB;
      next_mode = latchMode;
    end
    if (srst)
    begin
      next_stbSeen = 1'b0;
      next_codeA = `DCS_CODE_RST;
      next_codeB = `DCS_CODE_RST;
      next_mode = `DCS_MODE_DUAL;
    end
  end

  // channel b takes pair b, or channel a's output when cascaded
  assign chanBIn = (path == dcs_pkg::DCS_PATH_EXT) ? chanAOut : inB;

  dcs_delay_chan #(
    .CODE_W(CODE_W)
  ) u_chan_a (
    .clk_sys(clk_sys),
    .srst(srst),
    .din(inA),
    .code(delayChannelA),
    .dout(chanAOut)
  );

  dcs_delay_chan #(
    .CODE_W(CODE_W)
  ) u_chan_b (
    .clk_sys(clk_sys),
    .srst(srst),
    .din(chanBIn),
    .code(delayChannelB),
    .dout(chanBOut)
  );

  always_comb
  begin
    case (path)
      dcs_pkg::DCS_PATH_EXT:
      begin
        next_oAp = 1'b0;
        next_oAn = 1'b1;
      end
      default:
      begin
        next_oAp = chanAOut;
        next_oAn = ~chanAOut;
      end
    endcase
    next_oBp = chanBOut;
    next_oBn = ~chanBOut;
    if (srst)
    begin
      next_oAp = 1'b0;
      next_oAn = 1'b1;
      next_oBp = 1'b0;
      next_oBn = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    stbSeen <= next_stbSeen;
    delayChannelA <= next_codeA;
    delayChannelB <= next_codeB;
    pathModeBit <= next_mode;
    outputPairA_p <= next_oAp;
    outputPairA_n <= next_oAn;
    outputPairB_p <= next_oBp;
    outputPairB_n <= next_oBn;
  end
endmodule

/* dv/dcs_monitor.sv */
`timescale 1ns/100ps
module dcs_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // serial link
  input wire logic shiftClk,
  input wire logic serialDataIn,
  input wire logic latchStrobe
);
  logic [3:0] riseCnt;
  logic [3:0] next_riseCnt;
  logic [2:0] lowRun;
  logic [2:0] next_lowRun;

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  // shift edges since the link went idle
  always_comb
  begin
    next_lowRun = shiftClk ? 3'h0 : ((lowRun == 3'h7) ? lowRun : lowRun + 3'h1);
    next_riseCnt = riseCnt;
    if (shiftClk && lowRun != 3'h0 && !latchStrobe)
      next_riseCnt = (lowRun >= 3'h4) ? 4'h1 : riseCnt + 4'h1;
    else if (lowRun >= 3'h4)
      next_riseCnt = 4'h0;
    if (srst)
    begin
      next_lowRun = 3'h0;
      next_riseCnt = 4'h0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    lowRun <= next_lowRun;
    riseCnt <= next_riseCnt;
  end

  property p_clk_high;
    $rose(shiftClk) |=> shiftClk [*2];
  endproperty
  a_clk_high: assert property (p_clk_high) else $error("shift clock high too short");
  property p_clk_low;
    $fell(shiftClk) |=> !shiftClk [*2];
  endproperty
  a_clk_low: assert property (p_clk_low) else $error("shift clock low too short");
  property p_data_hold;
    shiftClk |-> $stable(serialDataIn);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved while clock high");
  property p_strobe_hold;
    shiftClk |-> $stable(latchStrobe);
  endproperty
  a_strobe_hold: assert property (p_strobe_hold) else $error("strobe moved while clock high");
  property p_strobe_len;
    $rose(latchStrobe) |-> latchStrobe [*6] ##1 !latchStrobe;
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe width wrong");
  property p_word_len;
    $rose(latchStrobe) |-> riseCnt == 4'hb;
  endproperty
  a_word_len: assert property (p_word_len) else $error("word not eleven bits");
  property p_tail;
    $fell(latchStrobe) |-> !shiftClk [*3] ##1 shiftClk [*3] ##1 !shiftClk;
  endproperty
  a_tail: assert property (p_tail) else $error("no closing edge after strobe");
  property p_idle;
    lowRun >= 3'h4 |-> !latchStrobe;
  endproperty
  a_idle: assert property (p_idle) else $error("strobe high while link idle");
endmodule

/* dv/delay_chain_serial_config_tb.sv */
`timescale 1ns/100ps
`include "dcs_defines.svh"
module delay_chain_serial_config_tb;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic cfgReq = 1'b0;
  logic cfgChannel = 1'b0;
  logic cfgMode = 1'b0;
  logic [8:0] cfgCode = 9'h000;
  logic cfgBusy, cfgDone, bothLoaded, pathModeBit;
  logic inputPairA_p = 1'b0;
  logic inputPairA_n = 1'b1;
  logic inputPairB_p = 1'b0;
  logic inputPairB_n = 1'b1;
  logic outputPairA_p, outputPairA_n, outputPairB_p, outputPairB_n;
  logic [8:0] delayChannelA, delayChannelB;
  logic [10:0] capWord = 11'h000;
  logic [10:0] seenWord = 11'h000;
  int miscompares = 0;
  int comparisons = 0;

  dcs_link_if lnk ();
  dcs_host u_dcs_host (.clk_sys(clk_sys), .srst(srst), .link(lnk), .cfgReq(cfgReq),
    .cfgChannel(cfgChannel), .cfgMode(cfgMode), .cfgCode(cfgCode), .cfgBusy(cfgBusy),
    .cfgDone(cfgDone), .bothLoaded(bothLoaded));
  dcs_device u_dcs_device (.clk_sys(clk_sys), .srst(srst), .link(lnk),
    .inputPairA_p(inputPairA_p), .inputPairA_n(inputPairA_n), .inputPairB_p(inputPairB_p),
    .inputPairB_n(inputPairB_n), .outputPairA_p(outputPairA_p), .outputPairA_n(outputPairA_n),
    .outputPairB_p(outputPairB_p), .outputPairB_n(outputPairB_n),
    .delayChannelA(delayChannelA), .delayChannelB(delayChannelB), .pathModeBit(pathModeBit));
  dcs_monitor u_dcs_monitor (.clk_sys(clk_sys), .srst(srst), .shiftClk(lnk.shiftClk),
    .serialDataIn(lnk.serialDataIn), .latchStrobe(lnk.latchStrobe));

  always #5 clk_sys = ~clk_sys;

  // word as seen on the wire, first bit ends at the bottom
  always @(posedge lnk.shiftClk)
  begin
    if (lnk.latchStrobe)
      seenWord <= capWord;
    capWord <= {lnk.serialDataIn, capWord[10:1]};
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one load, with a stray request while busy
  task automatic load(input logic ch, input logic md, input logic [8:0] cd);
    int n;
    n = 0;
    cfgChannel <= ch;
    cfgMode <= md;
    cfgCode <= cd;
    cfgReq <= 1'b1;
    @(posedge clk_sys);
    cfgReq <= 1'b0;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n == 1)
        chk("busyDuring", cfgBusy, 1'b1);
      cfgReq <= (n == 5);
    end
    while (cfgDone !== 1'b1 && n < 200);
    chk("doneLatency", n, 13 * 2 * `DCS_SCLK_HALF_CYC);
    repeat (5) @(posedge clk_sys);
    #1;
    chk("busyAfter", cfgBusy, 1'b0);
    chk("wireWord", seenWord, {cd, md, ch});
  endtask

  // rising input edge, count cycles to the output
  task automatic pulse(input bit inB, input bit outB, input int exp);
    int n;
    n = 0;
    if (inB)
      {inputPairB_p, inputPairB_n} <= 2'b10;
    else
      {inputPairA_p, inputPairA_n} <= 2'b10;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    while ((outB ? outputPairB_p : outputPairA_p) !== 1'b1 && n < 300);
    chk("pathLatency", n, exp);
    chk("pathInverse", outB ? outputPairB_n : outputPairA_n, 1'b0);
    {inputPairA_p, inputPairA_n, inputPairB_p, inputPairB_n} <= 4'h5;
    repeat (200) @(posedge clk_sys);
    #1;
  endtask

  task automatic t_reset;
    chk("codeA", delayChannelA, 9'h000);
    chk("mode", pathModeBit, 1'b0);
    chk("pairA", {outputPairA_p, outputPairA_n, outputPairB_p, outputPairB_n}, 4'h5);
    chk("both", bothLoaded, 1'b0);
  endtask

  task automatic t_dual;
    load(1'b0, 1'b0, 9'h0a5);
    chk("codeA", delayChannelA, 9'h0a5);
    chk("both", bothLoaded, 1'b0);
    load(1'b1, 1'b0, 9'h003);
    chk("codeB", delayChannelB, 9'h003);
    chk("codeA", delayChannelA, 9'h0a5);
    chk("both", bothLoaded, 1'b1);
    pulse(1'b0, 1'b0, 169);
    pulse(1'b1, 1'b1, 7);
  endtask

  task automatic t_ext;
    load(1'b0, 1'b1, 9'h002);
    chk("mode", pathModeBit, 1'b1);
    chk("codeB", delayChannelB, 9'h003);
    pulse(1'b0, 1'b1, 10);
    chk("pairA", {outputPairA_p, outputPairA_n}, 2'b01);
    load(1'b1, 1'b0, 9'h004);
    chk("mode", pathModeBit, 1'b0);
    chk("codeA", delayChannelA, 9'h002);
    chk("codeB", delayChannelB, 9'h004);
  endtask

  initial
  begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    #1;
    t_reset;
    t_dual;
    t_ext;
    stop_test;
  end

  initial
  begin
    #100000;
    miscompares++;
    stop_test;
  end
endmodule
